// file: design/svs_serializer.sv
// Top of the serial digital video serializer: input latch, sync forcing,
// clock multiplier with lock detect and rate sweep, shifter, registers.
// Assumes all inputs are synchronous to sys_clk and that the word clock
// period is ten or twenty sys_clk cycles (full or half rate).
//
// Behaviour
// - Recognise sync words 000-003, 3FC-3FF and eight bit 00, FF.
// - Upper eight bits all zero or all one force low two bits alike.
// - Inhibit input high passes every word unchanged, no detection.
// - Scramble serial bits with x^9 + x^4 + 1 shift register.
// - Scrambled bits go to NRZI: every one toggles the output.
// - Order: latch, sync detect, serialize, scramble, NRZI, driver.
// - Bit clock is ten times the word clock, one word per period.
// - Feedback path holds a divide by ten and a divide by two.
// - Serial output is suppressed while the loop is unlocked.
// - Lock output is high while locked, low otherwise.
// - Mode input picks auto, half rate on or half rate off.
// - Auto mode toggles full and half rate at sweep pace until lock.
// - Half rate on and off hold one fixed rate, no sweep.
// - Rate chosen automatically among supported rates up to 400 Mb/s; here only the 100 Mb/s full or 50 Mb/s half rate.
// - True and complement serial outputs carry the same bit.
//
// Design decisions made here: the register addresses and the strobed register port.
module svs_serializer
  import svs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Parallel video side
  input wire logic [WORD_W-1:0] parallel_word_in,
  input wire logic word_clock_in,
  input wire logic sync_force_inhibit,
  input wire logic [1:0] oscMode,
  // Serial side
  output logic serial_out_true,
  output logic serial_out_comp,
  output logic pll_locked_out,
  output logic syncWordSeen,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  output logic irq
);

  // Timing reference test on the upper eight bits
  function automatic logic isTrs(input logic [WORD_W-1:0] w);
    isTrs = (w[WORD_W-1:LOW_W] == UPPER_ZERO) ||
            (w[WORD_W-1:LOW_W] == UPPER_ONES);
  endfunction : isTrs

  // Low-bit forcing, bypassed under inhibit
  function automatic logic [WORD_W-1:0] forceLow(
    input logic [WORD_W-1:0] w,
    input logic inhibit
  );
    logic [WORD_W-1:0] r;
    r = w;
    if (!inhibit && w[WORD_W-1:LOW_W] == UPPER_ZERO)
      r[LOW_W-1:0] = LOW_ZERO;
    else if (!inhibit && w[WORD_W-1:LOW_W] == UPPER_ONES)
      r[LOW_W-1:0] = LOW_ONES;
    forceLow = r;
  endfunction : forceLow

  logic wordClkPrev_ff;
  logic wordEdge;
  logic [WORD_W-1:0] wordLatch_ff;
  logic syncWordSeen_ff;
  logic [BIT_CNT_W-1:0] bitCnt_ff;
  logic halfDiv_ff;
  logic halfRate_ff;
  logic bitTick;
  logic wordWrap;
  logic aligned;
  logic misaligned;
  logic [GOOD_CNT_W-1:0] goodCnt_ff;
  svs_lock_e lockState_ff;
  svs_lock_e nxt_lockState;
  logic [SWEEP_W-1:0] sweepCnt_ff;
  logic sweepFlip;
  svs_mode_e modeSel;
  logic [WORD_W-1:0] shift_ff;
  logic nrziBit;
  logic serialTrue_ff;
  logic [EVT_W-1:0] status_ff;
  logic [EVT_W-1:0] mask_ff;
  logic [EVT_W-1:0] evtSet;
  logic [DATA_W-1:0] regRdData_ff;
  logic locked;

  // Unused code 2'b11 falls back to auto
  assign modeSel = (oscMode == MODE_HALF_ON) ? MODE_HALF_ON :
                   (oscMode == MODE_HALF_OFF) ? MODE_HALF_OFF :
                   MODE_AUTO;

  // Rising edge of the word clock, inputs already synchronous
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      wordClkPrev_ff <= 1'b0;
    else
      wordClkPrev_ff <= word_clock_in;
  end

  assign wordEdge = word_clock_in && !wordClkPrev_ff;

  // Input latch with sync forcing applied on the way in
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      wordLatch_ff <= '0;
    else if (wordEdge)
      wordLatch_ff <= forceLow(parallel_word_in,
                               sync_force_inhibit);
  end

  // Sync seen flag for the latched word; held low under inhibit
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      syncWordSeen_ff <= 1'b0;
    else if (wordEdge)
      syncWordSeen_ff <= !sync_force_inhibit
                         && isTrs(parallel_word_in);
  end

  assign syncWordSeen = syncWordSeen_ff;

  // Bit tick: every cycle at full rate, every second at half rate
  assign bitTick = !halfRate_ff || halfDiv_ff;
  assign wordWrap = bitTick && (bitCnt_ff == BIT_LAST);
  // Phase compare: word edge must meet the end of the tenth bit
  assign aligned = wordEdge && wordWrap;
  assign misaligned = wordEdge != wordWrap;

  // Divide by two stage; realigned to the word edge on a phase error
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      halfDiv_ff <= 1'b0;
    else if (misaligned && wordEdge)
      halfDiv_ff <= 1'b0;
    else if (halfRate_ff)
      halfDiv_ff <= !halfDiv_ff;
    else
      halfDiv_ff <= 1'b0;
  end

  // Divide by ten counter, one count per serial bit
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      bitCnt_ff <= BIT_FIRST;
    else if (misaligned && wordEdge)
      bitCnt_ff <= BIT_FIRST;
    else if (wordWrap)
      bitCnt_ff <= BIT_FIRST;
    else if (bitTick)
      bitCnt_ff <= bitCnt_ff + 1'b1;
  end

  // Consecutive aligned words
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      goodCnt_ff <= '0;
    else if (misaligned)
      goodCnt_ff <= '0;
    else if (aligned && goodCnt_ff != LOCK_WORDS)
      goodCnt_ff <= goodCnt_ff + 1'b1;
  end

  // Lock state: any phase error drops back to hunting
  always_comb
  begin
    nxt_lockState = lockState_ff;
    case (lockState_ff)
      LK_HUNT:
        if (aligned)
          nxt_lockState = LK_TRACK;
      LK_TRACK:
        if (misaligned)
          nxt_lockState = LK_HUNT;
        else if (aligned && goodCnt_ff == LOCK_WORDS - 1'b1)
          nxt_lockState = LK_LOCKED;
      LK_LOCKED:
        if (misaligned)
          nxt_lockState = LK_HUNT;
      default:
        nxt_lockState = LK_HUNT;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      lockState_ff <= LK_HUNT;
    else
      lockState_ff <= nxt_lockState;
  end

  assign locked = (lockState_ff == LK_LOCKED);
  assign pll_locked_out = locked;

  // Sweep dwell counter, runs until lock in auto mode; a false track on
  // a harmonic must not restart it, or the sweep would never move on
  assign sweepFlip = (modeSel == MODE_AUTO) && !locked
                     && (sweepCnt_ff == SWEEP_LAST);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      sweepCnt_ff <= '0;
    else if (modeSel != MODE_AUTO || locked || sweepFlip)
      sweepCnt_ff <= '0;
    else
      sweepCnt_ff <= sweepCnt_ff + 1'b1;
  end

  // Oscillator rate: swept in auto, pinned otherwise; held once locked
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      halfRate_ff <= 1'b0;
    else if (modeSel == MODE_HALF_ON)
      halfRate_ff <= 1'b1;
    else if (modeSel == MODE_HALF_OFF)
      halfRate_ff <= 1'b0;
    else if (sweepFlip)
      halfRate_ff <= !halfRate_ff;
  end

  // Shifter: load at word end, then least significant bit first
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      shift_ff <= '0;
    else if (wordWrap)
      shift_ff <= wordLatch_ff;
    else if (bitTick)
      shift_ff <= {1'b0, shift_ff[WORD_W-1:1]};
  end

  // Scrambler and NRZI stage sit after the shifter
  svs_scrambler u_scrambler (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bitEn(bitTick),
    .bitIn(shift_ff[0]),
    .nrziBit(nrziBit)
  );

  // Driver stage; a dead line is safer than garbage while unlocked
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      serialTrue_ff <= 1'b0;
    else
      serialTrue_ff <= locked && nrziBit;
  end

  assign serial_out_true = serialTrue_ff;
  assign serial_out_comp = !serialTrue_ff;

  // Events that set sticky status bits
  assign evtSet[EVT_LOCK_GAIN] = (nxt_lockState == LK_LOCKED) && !locked;
  assign evtSet[EVT_LOCK_LOSS] = locked && (nxt_lockState != LK_LOCKED);
  assign evtSet[EVT_SYNC_SEEN] = wordEdge && !sync_force_inhibit
                                 && isTrs(parallel_word_in);

  // Sticky status, cleared by read; a new event beats the clear
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      status_ff <= '0;
    else if (regRdEn && regAddr == REG_STATUS)
      status_ff <= evtSet;
    else
      status_ff <= status_ff | evtSet;
  end

  // Interrupt mask
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      mask_ff <= MASK_RESET;
    else if (regWrEn && regAddr == REG_MASK)
      mask_ff <= regWrData[EVT_W-1:0];
  end

  assign irq = |(status_ff & mask_ff);

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      regRdData_ff <= DATA_ZERO;
    else if (!regRdEn)
      regRdData_ff <= DATA_ZERO;
    else if (regAddr == REG_STATUS)
      regRdData_ff <= {{(DATA_W-EVT_W){1'b0}}, status_ff};
    else if (regAddr == REG_MASK)
      regRdData_ff <= {{(DATA_W-EVT_W){1'b0}}, mask_ff};
    else if (regAddr == REG_STATE)
      regRdData_ff <= {{(DATA_W-ST_FSM_HI-1){1'b0}}, lockState_ff,
                       halfRate_ff, locked};
    else
      regRdData_ff <= DATA_ZERO;
  end

  assign regRdData = regRdData_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  force_zero_a: assert property (wordEdge && !sync_force_inhibit &&
      parallel_word_in[WORD_W-1:LOW_W] == UPPER_ZERO
      |=> wordLatch_ff == '0)
    else $error("all-zero sync word not forced");
  force_ones_a: assert property (wordEdge && !sync_force_inhibit &&
      parallel_word_in[WORD_W-1:LOW_W] == UPPER_ONES
      |=> &wordLatch_ff)
    else $error("all-ones sync word not forced");
  inhibit_pass_a: assert property (wordEdge && sync_force_inhibit
      |=> wordLatch_ff == $past(parallel_word_in) && !syncWordSeen)
    else $error("inhibited word altered");
  sync_flag_a: assert property (wordEdge && !sync_force_inhibit
      |=> syncWordSeen == ($past(parallel_word_in[WORD_W-1:LOW_W])
          == UPPER_ZERO || $past(parallel_word_in[WORD_W-1:LOW_W])
          == UPPER_ONES))
    else $error("sync detect flag wrong");
  full_rate_a: assert property (!halfRate_ff && bitCnt_ff == BIT_FIRST
      && !wordEdge ##1 (!wordEdge && !halfRate_ff) [*8]
      |=> bitCnt_ff == BIT_LAST)
    else $error("full rate word not ten bits");
  half_tick_a: assert property (halfRate_ff && bitTick && !wordEdge
      && $stable(halfRate_ff) |=> !halfDiv_ff)
    else $error("half rate ticks back to back");
  load_lsb_a: assert property (wordWrap
      |=> shift_ff == $past(wordLatch_ff))
    else $error("word not loaded into shifter");
  shift_lsb_a: assert property (bitTick && !wordWrap
      |=> shift_ff == ($past(shift_ff) >> 1))
    else $error("word not shifted lsb first");
  out_gate_a: assert property (!$past(locked) |-> !serial_out_true)
    else $error("serial out active while unlocked");
  comp_inv_a: assert property (serial_out_comp != serial_out_true)
    else $error("complement output not inverse");
  lock_rise_a: assert property ($rose(pll_locked_out)
      |-> $past(lockState_ff) == LK_TRACK && $past(aligned))
    else $error("lock without aligned tracking");
  lock_drop_a: assert property (locked && misaligned
      |=> !pll_locked_out)
    else $error("lock held after phase error");
  sweep_flip_a: assert property (sweepFlip |=> halfRate_ff
      != $past(halfRate_ff))
    else $error("auto sweep did not toggle");
  fixed_rate_a: assert property (modeSel == MODE_HALF_ON
      ##1 modeSel == MODE_HALF_ON |-> halfRate_ff && !sweepFlip)
    else $error("half rate on not held");
  sticky_set_a: assert property (regRdEn && regAddr == REG_STATUS
      && evtSet[EVT_SYNC_SEEN] |=> status_ff[EVT_SYNC_SEEN])
    else $error("event lost under read clear");

  lock_full_c: cover property ($rose(pll_locked_out) && !halfRate_ff);
  lock_half_c: cover property ($rose(pll_locked_out) && halfRate_ff);
  lock_loss_c: cover property ($fell(pll_locked_out));
  sync_seen_c: cover property (locked && evtSet[EVT_SYNC_SEEN]);

endmodule : svs_serializer

// file: design/svs_pkg.sv
// Constants, types and register map of the serial digital video serializer.
// Assumes one 100 MHz system clock; the word clock is sampled on it.
package svs_pkg;

  // Word and serial widths
  localparam int unsigned WORD_W = 10;
  localparam int unsigned UPPER_W = 8;
  localparam int unsigned LOW_W = 2;
  localparam logic [UPPER_W-1:0] UPPER_ZERO = 8'h00;
  localparam logic [UPPER_W-1:0] UPPER_ONES = 8'hFF;
  localparam logic [LOW_W-1:0] LOW_ZERO = 2'h0;
  localparam logic [LOW_W-1:0] LOW_ONES = 2'h3;

  // Clock multiplier: ten bits per word, optional halving
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'h9;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 4'h0;
  localparam int unsigned MAX_RATE_MBPS = 400;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_RATE_MBPS = 1000 / CLK_PERIOD_NS;

  // Lock qualification: aligned words in a row
  localparam int unsigned GOOD_CNT_W = 4;
  localparam logic [GOOD_CNT_W-1:0] LOCK_WORDS = 4'h8;

  // Auto standard sweep dwell
  localparam int unsigned SWEEP_TIME_NS = 20000;
  localparam int unsigned SWEEP_CYCLES = SWEEP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SWEEP_W = 12;
  localparam logic [SWEEP_W-1:0] SWEEP_LAST =
    SWEEP_W'(SWEEP_CYCLES - 1);

  // Scrambler: x^9 + x^4 + 1, history taps
  localparam int unsigned SCR_LEN = 9;
  localparam int unsigned SCR_TAP_A = 3;
  localparam int unsigned SCR_TAP_B = 8;

  // Register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h08;
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_LOCK_GAIN = 0;
  localparam int unsigned EVT_LOCK_LOSS = 1;
  localparam int unsigned EVT_SYNC_SEEN = 2;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
  localparam int unsigned ST_LOCKED = 0;
  localparam int unsigned ST_HALF = 1;
  localparam int unsigned ST_FSM_LO = 2;
  localparam int unsigned ST_FSM_HI = 3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Oscillator modes
  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_HALF_ON = 2'b01,
    MODE_HALF_OFF = 2'b10
  } svs_mode_e;

  // Lock state, Gray coded along hunt, track, locked
  typedef enum logic [1:0] {
    LK_HUNT = 2'b00,
    LK_TRACK = 2'b01,
    LK_LOCKED = 2'b11
  } svs_lock_e;

endpackage : svs_pkg

// file: design/svs_scrambler.sv
// Self-synchronising scrambler followed by the NRZ to NRZI stage.
// Assumes bitEn pulses once per serial bit, bitIn valid beside it.
module svs_scrambler
  import svs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Bit stream in
  input wire logic bitEn,
  input wire logic bitIn,
  // Encoded bit out
  output logic nrziBit
);

  logic [SCR_LEN-1:0] scrHist_ff;
  logic scrBit;
  logic nrziBit_ff;

  // Each output depends on the input bit and the fourth and ninth previous scrambled bits
  assign scrBit = bitIn ^ scrHist_ff[SCR_TAP_A]
                  ^ scrHist_ff[SCR_TAP_B];

  // Scrambler history, newest bit at the bottom
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      scrHist_ff <= '0;
    else if (bitEn)
      scrHist_ff <= {scrHist_ff[SCR_LEN-2:0], scrBit};
  end

  // A one toggles the line, a zero holds it
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      nrziBit_ff <= 1'b0;
    else if (bitEn)
      nrziBit_ff <= nrziBit_ff ^ scrBit;
  end

  assign nrziBit = nrziBit_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  scr_feedback_a: assert property (bitEn |=> scrHist_ff[0] ==
      ($past(bitIn) ^ $past(scrHist_ff[SCR_TAP_A])
       ^ $past(scrHist_ff[SCR_TAP_B])))
    else $error("scrambler feedback wrong");
  nrzi_toggle_a: assert property (bitEn |=> nrziBit_ff ==
      ($past(nrziBit_ff) ^ scrHist_ff[0]))
    else $error("nrzi transition wrong");
  idle_hold_a: assert property (!bitEn |=> $stable(nrziBit_ff)
      && $stable(scrHist_ff))
    else $error("encoder moved without a bit");

endmodule : svs_scrambler

// file: dv/svs_video_src.sv
// Model of the parallel video source that feeds the serializer.
// Assumes the bench supplies each next word and its control levels.
module svs_video_src
  import svs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control from the bench
  input wire logic run,
  input wire logic [4:0] period,
  input wire logic slip,
  input wire logic [WORD_W-1:0] srcWord,
  // Video side
  output logic [WORD_W-1:0] parallel_word_in,
  output logic word_clock_in,
  output logic wordLoad
);
  logic [4:0] cnt_ff;

  // Word phase counter; a slip stretches one period to break alignment
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !run)
      cnt_ff <= 5'h00;
    else if (slip)
      cnt_ff <= cnt_ff;
    else if (cnt_ff == period - 5'h01)
      cnt_ff <= 5'h00;
    else
      cnt_ff <= cnt_ff + 5'h01;
  end

  // Clock high in the first half, stands still while stopped
  assign word_clock_in = run && (cnt_ff < (period >> 1));
  assign wordLoad = run && (cnt_ff == (period >> 1));

  // Data moves at the falling word clock, far from the latch edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      parallel_word_in <= 10'h155;
    else if (wordLoad)
      parallel_word_in <= srcWord;
    else if (!run)
      parallel_word_in <= ~parallel_word_in; // Idle bus shows no stale word
  end
endmodule : svs_video_src

// file: dv/tb.sv
// Bench for the serializer: lock, decoded stream, registers, rate sweep.
// Assumes the video source model and a behavioural cable receiver here.
module tb
  import svs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic sync_force_inhibit = 1'b0;
  logic [1:0] oscMode = MODE_HALF_OFF;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWrData = DATA_ZERO;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic run = 1'b0;
  logic [4:0] period = 5'h0A;
  logic slip = 1'b0;
  logic [WORD_W-1:0] srcWord = 10'h000;
  logic [WORD_W-1:0] parallel_word_in;
  logic word_clock_in, wordLoad, serial_out_true, serial_out_comp;
  logic pll_locked_out, syncWordSeen, irq;
  logic [DATA_W-1:0] regRdData, rd, a;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h0000_d91c;
  int nWords = 0;
  logic [WORD_W-1:0] expQ[$];
  logic dq[$];
  logic capOn = 1'b0;
  logic prevY = 1'b0;
  logic prevLk = 1'b0;
  logic prevWc = 1'b0, wcEdge = 1'b0, expSeen = 1'b0;
  logic [8:0] sh = 9'h000;
  logic s, d;
  localparam logic [9:0] CORNER [10] = '{10'h000, 10'h001, 10'h002,
    10'h003, 10'h3FC, 10'h3FD, 10'h3FE, 10'h3FF, 10'h004, 10'h3FB};

  svs_serializer svs_serializer_inst(.sys_clk, .nrst, .parallel_word_in,
    .word_clock_in, .sync_force_inhibit, .oscMode, .serial_out_true,
    .serial_out_comp, .pll_locked_out, .syncWordSeen, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .irq);
  svs_video_src svs_video_src_inst(.sys_clk, .nrst, .run, .period, .slip,
    .srcWord, .parallel_word_in, .word_clock_in, .wordLoad);

  // Free running 100 MHz clock
  initial
    forever #5 sys_clk = ~sys_clk;

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Sync words fold their low bits unless inhibited
  function automatic logic [9:0] fold(logic [9:0] w, logic inh);
    if (!inh && w[9:2] === UPPER_ZERO)
      return {w[9:2], LOW_ZERO};
    if (!inh && w[9:2] === UPPER_ONES)
      return {w[9:2], LOW_ONES};
    return w;
  endfunction : fold

  task automatic reg_wr(logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= ad;
    regWrData <= v;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(logic [ADDR_W-1:0] ad, output logic [31:0] v);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= ad;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask : reg_rd

  task automatic wait_lock(logic val, int maxc, string name);
    int n;
    n = 0;
    #1;
    while (n < maxc && pll_locked_out !== val)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(name, 32'(val), 32'(pll_locked_out));
  endtask : wait_lock

  task automatic irq_is(logic v);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq", 32'(v), 32'(irq));
  endtask : irq_is

  // Decoded stream must hold the folded words in order, LSB first
  task automatic run_phase(logic inh);
    logic eb[$];
    int m;
    bit ok;
    @(posedge sys_clk);
    sync_force_inhibit <= inh;
    @(negedge sys_clk);
    expQ.delete();
    repeat (50) @(negedge sys_clk);
    dq.delete();
    capOn = 1'b1;
    repeat (230) @(negedge sys_clk);
    capOn = 1'b0;
    foreach (expQ[i])
      for (int b = 0; b < WORD_W; b++)
        eb.push_back(expQ[i][b]);
    ok = 1'b0;
    for (int k = 0; k + 220 <= eb.size(); k++)
    begin
      m = 0;
      for (int j = 20; j < 220; j++)
        m += int'(dq[j] !== eb[k + j]);
      ok |= (m == 0);
    end
    chk("stream", 1, 32'(ok));
  endtask : run_phase

  // Source feed: random words with sync corner words mixed in
  always @(posedge sys_clk)
  begin
    if (wordLoad)
    begin
      expQ.push_back(fold(srcWord, sync_force_inhibit));
      nWords++;
      srcWord <= (nWords % 3 == 0) ? CORNER[(nWords / 3) % 10]
                                   : 10'($random(seed));
    end
  end

  // Cable receiver: undo NRZI, then the self-synchronising scrambler
  always @(posedge sys_clk)
  begin
    s = serial_out_true ^ prevY;
    d = s ^ sh[3] ^ sh[8];
    sh <= {sh[7:0], s};
    prevY <= serial_out_true;
    if (capOn)
      dq.push_back(d);
  end

  // Output pair and gating watched every cycle
  always @(posedge sys_clk)
  begin
    if (nrst)
    begin
      chk("comp", 32'(!serial_out_true), 32'(serial_out_comp));
      if (!prevLk && !pll_locked_out)
        chk("gated", 0, 32'(serial_out_true));
    end
    prevLk <= pll_locked_out;
  end

  // Sync flag must follow each word taken on a rising word clock
  always @(posedge sys_clk)
  begin
    if (nrst && wcEdge)
      chk("sync_seen", 32'(expSeen), 32'(syncWordSeen));
    wcEdge <= word_clock_in && !prevWc;
    expSeen <= !sync_force_inhibit && (parallel_word_in[9:2] === UPPER_ZERO
               || parallel_word_in[9:2] === UPPER_ONES);
    prevWc <= word_clock_in;
  end

  // Bound well above the expected run length
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk("lock_rst", 0, 32'(pll_locked_out));
    chk("irq_rst", 0, 32'(irq));
    @(posedge sys_clk);
    run <= 1'b1;
    wait_lock(1, 300, "lock_full");
    irq_is(0);
    reg_wr(REG_MASK, 32'h0000_0001);
    irq_is(1);
    reg_rd(REG_STATUS, rd);
    chk("st_gain", 1, 32'(rd[EVT_LOCK_GAIN]));
    irq_is(0);
    reg_rd(REG_MASK, rd);
    chk("mask", 1, rd);
    reg_rd(8'h0C, rd);
    chk("unmapped", 0, rd);
    reg_wr(REG_STATE, 32'hFFFF_FFFF);
    reg_rd(REG_STATE, rd);
    chk("state", 32'h0000_000D, rd);
    run_phase(0);
    reg_rd(REG_STATUS, rd);
    chk("st_sync", 1, 32'(rd[EVT_SYNC_SEEN]));
    run_phase(1);
    reg_rd(REG_STATUS, rd);
    reg_rd(REG_STATUS, rd);
    chk("st_inh", 0, 32'(rd[EVT_SYNC_SEEN]));
    chk("seen_inh", 0, 32'(syncWordSeen));
    reg_wr(REG_MASK, 32'h0000_0002);
    reg_rd(REG_STATUS, rd);
    @(posedge sys_clk);
    slip <= 1'b1;
    @(posedge sys_clk);
    slip <= 1'b0;
    wait_lock(0, 40, "lock_loss");
    irq_is(1);
    @(posedge sys_clk);
    run <= 1'b0;
    oscMode <= MODE_AUTO;
    repeat (5) @(posedge sys_clk);
    reg_rd(REG_STATE, a);
    repeat (1998) @(posedge sys_clk);
    reg_rd(REG_STATE, rd);
    chk("sweep", 32'(!a[ST_HALF]), 32'(rd[ST_HALF]));
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      oscMode <= i ? MODE_HALF_OFF : MODE_HALF_ON;
      repeat (3) @(posedge sys_clk);
      reg_rd(REG_STATE, a);
      repeat (2500) @(posedge sys_clk);
      reg_rd(REG_STATE, rd);
      chk("half_set", 32'(i == 0), 32'(a[ST_HALF]));
      chk("half_hold", 32'(i == 0), 32'(rd[ST_HALF]));
    end
    @(posedge sys_clk);
    period <= 5'h14;
    run <= 1'b1;
    oscMode <= MODE_AUTO;
    wait_lock(1, 6000, "lock_auto");
    reg_rd(REG_STATE, rd);
    chk("auto_half", 3, 32'(rd[1:0]));
    stop_test();
  end
endmodule : tb
